// ### mrxc_pkg.sv
// Purpose: constants, register map and reset values for the receive checker
// Assumes: 32-bit register words, byte addresses are four times the word index
// Notes: lane marker words keep the low half at the even index
package mrxc_pkg;
	localparam int REG_WORDS = 112;
	localparam int LANES = 20;
	localparam int R_CTRL = 0;
	localparam int R_MAXLEN = 1;
	localparam int R_MINLEN = 2;
	localparam int R_SPACING = 3;
	localparam int R_UCAST = 4;
	localparam int R_MCAST = 6;
	localparam int R_PSA = 8;
	localparam int R_GCP_ET = 10;
	localparam int R_GCP_OP = 11;
	localparam int R_PCP_ET = 12;
	localparam int R_PCP_OP = 13;
	localparam int R_GPP = 14;
	localparam int R_PPP = 15;
	localparam int R_TXG_DA = 16;
	localparam int R_TXG_SA = 18;
	localparam int R_TXG_CODE = 20;
	localparam int R_TXP_DA = 21;
	localparam int R_TXP_SA = 23;
	localparam int R_TXP_CODE = 25;
	localparam int R_STATUS = 26;
	localparam int R_TXM = 32;
	localparam int R_RXM = 72;
	localparam int R_END = 112;
	localparam int B_PRE_CHK = 0;
	localparam int B_SFD_CHK = 1;
	localparam int B_STRIP = 2;
	localparam int B_IGN_FCS = 3;
	localparam int B_LFI_EN = 4;
	localparam int B_ACK_CHK = 5;
	localparam int B_FWD_CTRL = 6;
	localparam logic [31:0] CTRL_RST = 32'h0000_0024;
	localparam logic [14:0] MAXLEN_RST = 15'h2580;
	localparam logic [7:0] MINLEN_RST = 8'h40;
	localparam logic [15:0] SPACING_RST = 16'h3fff;
	localparam logic [47:0] MCAST_RST = 48'h0180c2000001;
	localparam logic [15:0] CTRL_ET_RST = 16'h8808;
	localparam logic [15:0] OP_MIN_RST = 16'h0000;
	localparam logic [15:0] OP_MAX_RST = 16'hffff;
	localparam logic [15:0] GPP_OP_RST = 16'h0001;
	localparam logic [15:0] PPP_OP_RST = 16'h0101;
	localparam int MAXLEN_LIMIT = 16383;
	localparam logic [15:0] MIN_FRAME = 16'h0040;
	localparam logic [15:0] FCS_BYTES = 16'h0004;
	localparam logic [15:0] FCS_KEEP_LEN = 16'h0008;
	localparam logic [15:0] HDR_BYTES = 16'h0012;
	localparam logic [55:0] PREAMBLE = 56'h55555555555555;
	localparam logic [7:0] SFD = 8'hd5;
	localparam logic [63:0] MARKER_RST [LANES] = '{
		64'hc16821003e97de00, 64'h9d718e00628e7100, 64'h594be800a6b41700,
		64'h4d957b00b26a8400, 64'hf50709000af8f600, 64'hdd14c20022eb3d00,
		64'h9a4a260065b5d900, 64'h7b45660084ba9900, 64'ha02476005fdb8900,
		64'h68c9fb0097360400, 64'hfd6c990002936600, 64'hb9915500466eaa00,
		64'h5cb9b200a3464d00, 64'h1af8bd00e5074200, 64'h83c7ca007c383500,
		64'h3536cd00cac93200, 64'hc4314c003bceb300, 64'hadd6b70052294800,
		64'h5f662a00a099d500, 64'hc0f0e5003f0f1a00};

	typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_DECIDE, ST_PLAY} mrxc_state_t;

	function automatic logic [31:0] reset_word(input int idx);
		logic [63:0] m;
		m = 64'h0;
		if (idx >= R_TXM && idx < R_END) m = MARKER_RST[((idx - R_TXM) / 2) % LANES];
		case (idx)
			R_CTRL: reset_word = CTRL_RST;
			R_MAXLEN: reset_word = {17'h0, MAXLEN_RST};
			R_MINLEN: reset_word = {24'h0, MINLEN_RST};
			R_SPACING: reset_word = {16'h0, SPACING_RST};
			R_MCAST, R_TXG_DA, R_TXP_DA: reset_word = MCAST_RST[31:0];
			R_MCAST + 1, R_TXG_DA + 1, R_TXP_DA + 1: reset_word = {16'h0, MCAST_RST[47:32]};
			R_GCP_ET, R_PCP_ET: reset_word = {16'h0, CTRL_ET_RST};
			R_GCP_OP, R_PCP_OP: reset_word = {OP_MAX_RST, OP_MIN_RST};
			R_GPP, R_TXG_CODE: reset_word = {GPP_OP_RST, CTRL_ET_RST};
			R_PPP, R_TXP_CODE: reset_word = {PPP_OP_RST, CTRL_ET_RST};
			default: reset_word = idx[0] ? m[63:32] : m[31:0];
		endcase
	endfunction
endpackage

// ### mrxc_top.sv
// Purpose: receive frame checker with lane marker and pause settings
// Assumes: byte-wide receive stream, FCS verdict supplied with the last byte
// Notes: a frame is stored up to max_len bytes, judged, then played out unless dropped
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module mrxc_top #(
	parameter int BUF_BYTES = 16384
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic [8:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_rx_valid,
	input wire logic i_rx_sop,
	input wire logic i_rx_eop,
	input wire logic [7:0] i_rx_data,
	input wire logic [55:0] i_rx_preamble,
	input wire logic [7:0] i_rx_sfd,
	input wire logic i_rx_fcs_bad,
	input wire logic i_rx_local_fault,
	input wire logic i_rx_start_block,
	output logic o_rx_ready,
	output logic [7:0] o_rx_data,
	output logic o_rx_segment_valid_out,
	output logic o_rx_sop,
	output logic o_rx_eop,
	output logic o_rx_err,
	output logic o_stat_rx_good,
	output logic o_stat_rx_bad_fcs,
	input wire logic [8:0] i_rx_pause_ack,
	output logic [8:0] o_rx_pause_req,
	input wire logic [4:0] i_tx_lane,
	output logic [63:0] o_tx_lane_marker,
	input wire logic i_rx_am_valid,
	input wire logic [63:0] i_rx_am_word,
	input wire logic i_rx_lane_word_valid,
	output logic o_rx_am_hit,
	output logic [4:0] o_rx_am_lane,
	output logic o_rx_am_spacing_err,
	input wire logic i_tx_pause_prio,
	output logic [127:0] o_tx_pause_header
);
	localparam int AW = $clog2(BUF_BYTES);
	if (BUF_BYTES < mrxc_pkg::MAXLEN_LIMIT) begin : g_buf_chk
		$error("frame buffer smaller than the largest maximum length");
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	// register bus: one wait cycle, then the answer
	logic [31:0] cfg_q [mrxc_pkg::REG_WORDS];
	logic ack_q;
	logic [31:0] rdata_q;
	wire [6:0] reg_idx = i_avs_address[8:2];
	wire bus_req = i_avs_read | i_avs_write;
	wire reg_mapped = (reg_idx < 7'(mrxc_pkg::R_STATUS)) ||
		(reg_idx >= 7'(mrxc_pkg::R_TXM) && reg_idx < 7'(mrxc_pkg::R_END));
	wire wr_go = i_avs_write & ack_q & reg_mapped;
	logic [31:0] status_w;
	wire [31:0] rd_word = (reg_idx == 7'(mrxc_pkg::R_STATUS)) ? status_w :
		reg_mapped ? cfg_q[reg_idx] : 32'h0;
	assign o_avs_waitrequest = bus_req & ~ack_q;
	assign o_avs_readdata = rdata_q;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= bus_req & ~ack_q;
			rdata_q <= (i_avs_read & ~ack_q) ? rd_word : rdata_q;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int i = 0; i < mrxc_pkg::REG_WORDS; i++) cfg_q[i] <= mrxc_pkg::reset_word(i);
		end else if (wr_go) begin
			for (int b = 0; b < 4; b++)
				if (i_avs_byteenable[b]) cfg_q[reg_idx][8*b +: 8] <= i_avs_writedata[8*b +: 8];
		end
	end

	// settings
	wire [31:0] ctrl = cfg_q[mrxc_pkg::R_CTRL];
	wire pre_chk = ctrl[mrxc_pkg::B_PRE_CHK];
	wire sfd_chk = ctrl[mrxc_pkg::B_SFD_CHK];
	wire strip_en = ctrl[mrxc_pkg::B_STRIP];
	wire ign_fcs = ctrl[mrxc_pkg::B_IGN_FCS];
	wire lfi_en = ctrl[mrxc_pkg::B_LFI_EN];
	wire ack_chk = ctrl[mrxc_pkg::B_ACK_CHK];
	wire fwd_ctrl = ctrl[mrxc_pkg::B_FWD_CTRL];
	wire [15:0] max_len = {1'b0, cfg_q[mrxc_pkg::R_MAXLEN][14:0]};
	wire [15:0] min_len = {8'h0, cfg_q[mrxc_pkg::R_MINLEN][7:0]};
	wire [16:0] spacing_exp = {1'b0, cfg_q[mrxc_pkg::R_SPACING][15:0]} + 17'h1;
	wire [47:0] ucast = {cfg_q[mrxc_pkg::R_UCAST + 1][15:0], cfg_q[mrxc_pkg::R_UCAST]};
	wire [47:0] mcast = {cfg_q[mrxc_pkg::R_MCAST + 1][15:0], cfg_q[mrxc_pkg::R_MCAST]};
	wire [47:0] psa = {cfg_q[mrxc_pkg::R_PSA + 1][15:0], cfg_q[mrxc_pkg::R_PSA]};
	wire [31:0] gcp_op = cfg_q[mrxc_pkg::R_GCP_OP];
	wire [31:0] pcp_op = cfg_q[mrxc_pkg::R_PCP_OP];
	wire [31:0] gpp = cfg_q[mrxc_pkg::R_GPP];
	wire [31:0] ppp = cfg_q[mrxc_pkg::R_PPP];

	// receive frame path
	mrxc_pkg::mrxc_state_t state_q, state_d;
	logic [7:0] mem [BUF_BYTES];
	logic [15:0] len_q, out_len_q;
	logic [15:0] rd_q;
	logic [143:0] hdr_q;
	logic fcs_bad_q, hdr_bad_q, abort_q, fault_q, pkt_err_q, sa_match_q;
	logic [8:0] pend_q;
	assign o_rx_ready = (state_q == mrxc_pkg::ST_IDLE) || (state_q == mrxc_pkg::ST_FILL);
	wire take = i_rx_valid & o_rx_ready;
	wire lfi_now = lfi_en & i_rx_local_fault;
	wire start_ok = (state_q == mrxc_pkg::ST_IDLE) & take & i_rx_sop & ~fault_q & ~lfi_now;
	wire in_fill = state_q == mrxc_pkg::ST_FILL;
	wire acc_byte = start_ok | (in_fill & take & ~lfi_now);
	wire store = acc_byte & (len_q < max_len);
	wire decide = state_q == mrxc_pkg::ST_DECIDE;
	wire [47:0] f_da = hdr_q[143:96];
	wire [47:0] f_sa = hdr_q[95:48];
	wire [15:0] f_et = hdr_q[47:32];
	wire [15:0] f_op = hdr_q[31:16];
	wire over = len_q > max_len;
	wire under = len_q < min_len;
	wire short = len_q < mrxc_pkg::MIN_FRAME;
	wire da_match = (f_da == ucast) || (f_da == mcast);
	wire gcp_hit = f_et == cfg_q[mrxc_pkg::R_GCP_ET][15:0] &&
		f_op >= gcp_op[15:0] && f_op <= gcp_op[31:16];
	wire pcp_hit = f_et == cfg_q[mrxc_pkg::R_PCP_ET][15:0] &&
		f_op >= pcp_op[15:0] && f_op <= pcp_op[31:16];
	wire drop = ~abort_q & (short | ((gcp_hit | pcp_hit) & ~fwd_ctrl));
	wire strip = strip_en & ~abort_q & (len_q > mrxc_pkg::FCS_KEEP_LEN);
	wire [15:0] out_len = over ? max_len : strip ? len_q - mrxc_pkg::FCS_BYTES : len_q;
	wire fcs_err = fcs_bad_q & ~ign_fcs;
	wire pkt_err = abort_q | over | under | fcs_err | hdr_bad_q;
	wire good = ~(abort_q | over | under | hdr_bad_q | fcs_err);
	wire pause_ok = decide & ~short & ~abort_q & da_match;
	wire gpp_hit = pause_ok && f_et == gpp[15:0] && f_op == gpp[31:16];
	wire ppp_hit = pause_ok && f_et == ppp[15:0] && f_op == ppp[31:16];
	wire [8:0] pause_set = {gpp_hit, ppp_hit ? hdr_q[7:0] : 8'h0};
	wire [8:0] pause_clr = ack_chk ? i_rx_pause_ack : 9'h1ff;
	wire last = rd_q == out_len_q - 16'h1;
	assign status_w = {21'h0, sa_match_q, fault_q, pend_q};
	assign o_rx_pause_req = pend_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			mrxc_pkg::ST_IDLE: if (start_ok) state_d = i_rx_eop ? mrxc_pkg::ST_DECIDE : mrxc_pkg::ST_FILL;
			mrxc_pkg::ST_FILL: if (lfi_now || (take && i_rx_eop)) state_d = mrxc_pkg::ST_DECIDE;
			mrxc_pkg::ST_DECIDE: state_d = drop ? mrxc_pkg::ST_IDLE : mrxc_pkg::ST_PLAY;
			mrxc_pkg::ST_PLAY: if (last) state_d = mrxc_pkg::ST_IDLE;
			default: state_d = mrxc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (store) mem[len_q[AW-1:0]] <= i_rx_data;
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q <= mrxc_pkg::ST_IDLE;
			len_q <= 16'h0;
			hdr_q <= 144'h0;
			fcs_bad_q <= 1'b0;
			hdr_bad_q <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_d == mrxc_pkg::ST_IDLE) len_q <= 16'h0;
			else if (acc_byte && len_q != 16'hffff) len_q <= len_q + 16'h1;
			if (acc_byte && len_q < mrxc_pkg::HDR_BYTES) hdr_q <= {hdr_q[135:0], i_rx_data};
			if (start_ok) begin
				hdr_bad_q <= (pre_chk & (i_rx_preamble != mrxc_pkg::PREAMBLE)) |
					(sfd_chk & (i_rx_sfd != mrxc_pkg::SFD));
				abort_q <= 1'b0;
				fcs_bad_q <= 1'b0;
			end
			if (acc_byte & i_rx_eop) fcs_bad_q <= i_rx_fcs_bad;
			if (in_fill & lfi_now) abort_q <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rd_q <= 16'h0;
			out_len_q <= 16'h0;
			pkt_err_q <= 1'b0;
			o_rx_data <= 8'h0;
			o_rx_segment_valid_out <= 1'b0;
			o_rx_sop <= 1'b0;
			o_rx_eop <= 1'b0;
			o_rx_err <= 1'b0;
		end else begin
			if (decide) begin
				rd_q <= 16'h0;
				out_len_q <= out_len;
				pkt_err_q <= pkt_err;
			end else if (state_q == mrxc_pkg::ST_PLAY) begin
				rd_q <= rd_q + 16'h1;
			end
			o_rx_segment_valid_out <= state_q == mrxc_pkg::ST_PLAY;
			o_rx_data <= (state_q == mrxc_pkg::ST_PLAY) ? mem[rd_q[AW-1:0]] : 8'h0;
			o_rx_sop <= (state_q == mrxc_pkg::ST_PLAY) && rd_q == 16'h0;
			o_rx_eop <= (state_q == mrxc_pkg::ST_PLAY) && last;
			o_rx_err <= (state_q == mrxc_pkg::ST_PLAY) && last && pkt_err_q;
		end
	end

	// fault, pause and statistics; a new event wins over its clear
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fault_q <= 1'b0;
			pend_q <= 9'h0;
			sa_match_q <= 1'b0;
			o_stat_rx_good <= 1'b0;
			o_stat_rx_bad_fcs <= 1'b0;
		end else begin
			fault_q <= lfi_now | (fault_q & ~(~i_rx_local_fault & i_rx_start_block));
			pend_q <= (pend_q & ~pause_clr) | pause_set;
			if (pause_ok) sa_match_q <= f_sa == psa;
			o_stat_rx_good <= decide & ~drop & good;
			o_stat_rx_bad_fcs <= decide & fcs_bad_q;
		end
	end

	// lane markers
	logic [63:0] txm_w [mrxc_pkg::LANES];
	logic [mrxc_pkg::LANES-1:0] am_eq;
	logic [4:0] am_lane_w;
	logic [16:0] words_q;
	for (genvar g = 0; g < mrxc_pkg::LANES; g++) begin : g_lane
		assign txm_w[g] = {cfg_q[mrxc_pkg::R_TXM + 2*g + 1], cfg_q[mrxc_pkg::R_TXM + 2*g]};
		assign am_eq[g] = i_rx_am_word ==
			{cfg_q[mrxc_pkg::R_RXM + 2*g + 1], cfg_q[mrxc_pkg::R_RXM + 2*g]};
	end

	always_comb begin
		am_lane_w = 5'h0;
		for (int l = mrxc_pkg::LANES - 1; l >= 0; l--)
			if (am_eq[l]) am_lane_w = 5'(l);
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_tx_lane_marker <= 64'h0;
			o_rx_am_hit <= 1'b0;
			o_rx_am_lane <= 5'h0;
			words_q <= 17'h0;
			o_rx_am_spacing_err <= 1'b0;
			o_tx_pause_header <= 128'h0;
		end else begin
			o_tx_lane_marker <= (i_tx_lane < 5'(mrxc_pkg::LANES)) ? txm_w[i_tx_lane] : 64'h0;
			o_rx_am_hit <= i_rx_am_valid & (|am_eq);
			o_rx_am_lane <= i_rx_am_valid ? am_lane_w : o_rx_am_lane;
			o_rx_am_spacing_err <= i_rx_am_valid && words_q != spacing_exp;
			if (i_rx_am_valid) words_q <= 17'h0;
			else if (i_rx_lane_word_valid && words_q != 17'h1ffff) words_q <= words_q + 17'h1;
			o_tx_pause_header <= i_tx_pause_prio ?
				{cfg_q[mrxc_pkg::R_TXP_DA + 1][15:0], cfg_q[mrxc_pkg::R_TXP_DA],
				cfg_q[mrxc_pkg::R_TXP_SA + 1][15:0], cfg_q[mrxc_pkg::R_TXP_SA],
				cfg_q[mrxc_pkg::R_TXP_CODE][15:0], cfg_q[mrxc_pkg::R_TXP_CODE][31:16]} :
				{cfg_q[mrxc_pkg::R_TXG_DA + 1][15:0], cfg_q[mrxc_pkg::R_TXG_DA],
				cfg_q[mrxc_pkg::R_TXG_SA + 1][15:0], cfg_q[mrxc_pkg::R_TXG_SA],
				cfg_q[mrxc_pkg::R_TXG_CODE][15:0], cfg_q[mrxc_pkg::R_TXG_CODE][31:16]};
		end
	end

	// remembers a frame kept with fcs_err set until its last byte has left, and how long that takes
	logic fcs_due_q;
	logic [15:0] fcs_wait_q;
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fcs_due_q <= 1'b0;
			fcs_wait_q <= 16'h0;
		end else begin
			fcs_due_q <= (decide & fcs_err & ~drop) | (fcs_due_q & ~o_rx_eop);
			fcs_wait_q <= fcs_due_q ? fcs_wait_q + 16'h1 : 16'h0;
		end
	end

	fcs_flag_a: assert property (fcs_due_q && o_rx_eop |-> o_rx_err)
		else $error("bad fcs frame not flagged");
	fcs_wait_a: assert property (fcs_due_q |-> fcs_wait_q <= out_len_q)
		else $error("bad fcs frame never ended");
	fcs_stat_a: assert property (decide && fcs_bad_q |=> o_stat_rx_bad_fcs)
		else $error("bad fcs status missing");
	short_drop_a: assert property (decide && short && !abort_q |=> state_q == mrxc_pkg::ST_IDLE)
		else $error("short frame not dropped");
	strip_len_a: assert property (decide && strip && !over |=> out_len_q == $past(len_q) - 16'h4)
		else $error("fcs strip length wrong");
	trunc_len_a: assert property (decide && over && !drop |=> out_len_q == max_len)
		else $error("oversize frame not truncated");
	ctrl_drop_a: assert property (decide && !short && !abort_q && (gcp_hit || pcp_hit) && !fwd_ctrl
		|=> state_q == mrxc_pkg::ST_IDLE)
		else $error("control frame not dropped");
	fault_hold_a: assert property (fault_q && state_q == mrxc_pkg::ST_IDLE |=> state_q == mrxc_pkg::ST_IDLE)
		else $error("frame accepted during fault");
	ack_wait_a: assert property (ack_chk && i_rx_pause_ack == 9'h0 && pend_q != 9'h0
		|=> (pend_q & $past(pend_q)) == $past(pend_q))
		else $error("pause request dropped before ack");
	spacing_chk_a: assert property (i_rx_am_valid && words_q != spacing_exp |=> o_rx_am_spacing_err)
		else $error("marker spacing error missed");
	lane_id_a: assert property (i_rx_am_valid && am_eq[0] |=> o_rx_am_hit && o_rx_am_lane == 5'h0)
		else $error("lane zero marker not identified");

	good_frame_c: cover property (o_rx_eop && !o_rx_err);
	err_frame_c: cover property (o_rx_eop && o_rx_err);
	pause_c: cover property (gpp_hit ##[1:4] pend_q == 9'h0);
	fault_c: cover property (in_fill && lfi_now);
endmodule // mrxc_top

// ### mrxc_user_model.sv
// Purpose: user logic sitting on the receive packet stream and pause handshake
// Assumes: one byte per cycle out of the checker, no backpressure
// Notes: counters and captured bytes clear on i_clear; acknowledges only while i_ack_go is high
`timescale 1ns/1ps
module mrxc_user_model (
	input wire logic i_core_clk,
	input wire logic i_clear,
	input wire logic i_valid,
	input wire logic i_sop,
	input wire logic i_eop,
	input wire logic [7:0] i_data,
	input wire logic i_err,
	input wire logic i_good,
	input wire logic i_bad,
	input wire logic [8:0] i_pause_req,
	input wire logic i_ack_go,
	output logic [8:0] o_pause_ack,
	output logic [15:0] o_bytes,
	output logic o_err,
	output logic [7:0] o_good,
	output logic [7:0] o_bad,
	output logic [7:0] o_first_byte,
	output logic [7:0] o_last_byte
);
	always_ff @(posedge i_core_clk) begin
		if (i_clear) begin
			o_bytes <= 16'h0;
			o_err <= 1'b0;
			o_good <= 8'h0;
			o_bad <= 8'h0;
			o_first_byte <= 8'h0;
			o_last_byte <= 8'h0;
		end else begin
			if (i_valid) o_bytes <= o_bytes + 16'h1;
			if (i_valid && i_sop) o_first_byte <= i_data;
			if (i_valid && i_eop) o_last_byte <= i_data;
			if (i_valid && i_eop) o_err <= i_err;
			if (i_good) o_good <= o_good + 8'h1;
			if (i_bad) o_bad <= o_bad + 8'h1;
		end
	end
	// a slow user simply holds i_ack_go low for a while
	assign o_pause_ack = i_pause_req & {9{i_ack_go}};
endmodule // mrxc_user_model

// ### mrxc_top_tb.sv
// Purpose: self-checking bench for the receive checker
// Assumes: settings written over the register bus between frames
// Notes: reset values and markers first, then frame rows, pause, fault and reset cases
`timescale 1ns/1ps
module mrxc_top_tb;
	typedef struct {logic [7:0] c; logic [14:0] mx; logic [7:0] mn; int n;
		logic fcs, pbad, sbad, lf; int xn; logic xe, xb; logic [1:0] xg;} mrxc_row_t;
	logic clk, rst, rd, wr, v, sop, eop, fcs, lf, sb, amv, lwv, prio, ack_go, clr;
	logic [8:0] addr, preq, pack;
	logic [31:0] wd, avs_rdata, q;
	logic [7:0] dat, sfd, ngood, nbad, od, fb, lb;
	logic [55:0] pre;
	logic [4:0] lane, hlane;
	logic [63:0] amw, txm;
	logic [127:0] hdr;
	logic [15:0] nbytes;
	logic avs_wait, ready, ov, osop, oeop, oerr, sgood, sbadf, hit, serr, lerr, e;
	logic [7:0] frm [128];
	int bad_count, compares, cyc;
	mrxc_row_t rows [11] = '{
		'{8'h24, 15'h2580, 8'h40, 64, 0, 0, 0, 0, 60, 0, 0, 1},
		'{8'h20, 15'h2580, 8'h40, 100, 0, 0, 0, 0, 100, 0, 0, 1},
		'{8'h24, 15'h2580, 8'h40, 64, 1, 0, 0, 0, 60, 1, 1, 0},
		'{8'h2c, 15'h2580, 8'h40, 64, 1, 0, 0, 0, 60, 0, 1, 1},
		'{8'h24, 15'h2580, 8'h40, 63, 0, 0, 0, 0, 0, 0, 0, 0},
		'{8'h24, 15'h0040, 8'h40, 70, 0, 0, 0, 0, 64, 1, 0, 2},
		'{8'h24, 15'h2580, 8'h50, 70, 0, 0, 0, 0, 66, 1, 0, 2},
		'{8'h25, 15'h2580, 8'h40, 64, 0, 1, 0, 0, 60, 1, 0, 2},
		'{8'h24, 15'h2580, 8'h40, 64, 0, 1, 0, 0, 60, 0, 0, 1},
		'{8'h26, 15'h2580, 8'h40, 64, 0, 0, 1, 0, 60, 1, 0, 2},
		'{8'h24, 15'h2580, 8'h40, 64, 0, 0, 0, 1, 60, 0, 0, 1}};
	int ri [10] = '{0, 1, 2, 3, 6, 7, 20, 45, 84, 27};
	logic [31:0] rv [10] = '{32'h24, 32'h2580, 32'h40, 32'h3fff, 32'hc2000001, 32'h0180,
		32'h00018808, 32'h9a4a2600, 32'h65b5d900, 32'h0};

	mrxc_top mrxc_top_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait), .i_rx_valid(v),
		.i_rx_sop(sop), .i_rx_eop(eop), .i_rx_data(dat), .i_rx_preamble(pre), .i_rx_sfd(sfd),
		.i_rx_fcs_bad(fcs), .i_rx_local_fault(lf), .i_rx_start_block(sb), .o_rx_ready(ready),
		.o_rx_data(od), .o_rx_segment_valid_out(ov), .o_rx_sop(osop), .o_rx_eop(oeop),
		.o_rx_err(oerr), .o_stat_rx_good(sgood), .o_stat_rx_bad_fcs(sbadf),
		.i_rx_pause_ack(pack), .o_rx_pause_req(preq), .i_tx_lane(lane),
		.o_tx_lane_marker(txm), .i_rx_am_valid(amv), .i_rx_am_word(amw),
		.i_rx_lane_word_valid(lwv), .o_rx_am_hit(hit), .o_rx_am_lane(hlane),
		.o_rx_am_spacing_err(serr), .i_tx_pause_prio(prio), .o_tx_pause_header(hdr));
	mrxc_user_model mrxc_user_model_inst (.i_core_clk(clk), .i_clear(clr), .i_valid(ov),
		.i_sop(osop), .i_eop(oeop), .i_data(od), .i_err(oerr), .i_good(sgood), .i_bad(sbadf),
		.i_pause_req(preq), .i_ack_go(ack_go), .o_pause_ack(pack), .o_bytes(nbytes),
		.o_err(lerr), .o_good(ngood), .o_bad(nbad), .o_first_byte(fb), .o_last_byte(lb));

	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end

	task automatic chk(input logic [127:0] s, input logic [127:0] x);
		compares++;
		if (s !== x) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// request held until the edge that sees waitrequest low; only the bench timeout ends a wait
	task automatic bus(input logic w, input int idx, input logic [31:0] d);
		@(posedge clk);
		addr <= 9'(idx * 4);
		wr <= w;
		rd <= !w;
		wd <= d;
		@(posedge clk);
		while (avs_wait !== 1'b0) @(posedge clk);
		q = avs_rdata;
		rd <= 0;
		wr <= 0;
	endtask
	task automatic idle_wait();
		int t;
		t = 0;
		repeat (4) @(negedge clk);
		while (ready !== 1'b1 && t < 300) begin @(negedge clk); t++; end
	endtask
	// fa stops the frame early and raises the fault at that byte
	task automatic send(input int n, input int fa, input logic [55:0] p, input logic [7:0] s);
		idle_wait();
		@(posedge clk);
		clr <= 1; pre <= p; sfd <= s;
		@(posedge clk);
		clr <= 0;
		for (int i = 0; i < n; i++) begin
			if (i == fa) begin lf <= 1; break; end
			v <= 1; sop <= i == 0; eop <= i == n - 1; dat <= i < 128 ? frm[i] : i[7:0];
			@(posedge clk);
		end
		v <= 0; sop <= 0; eop <= 0;
		idle_wait();
		// the last output byte is counted by the user model one edge after ready returns
		@(negedge clk);
	endtask
	task automatic pframe(input logic [15:0] op, input logic [7:0] cls);
		for (int i = 0; i < 128; i++) frm[i] = i[7:0];
		{frm[0], frm[1], frm[2], frm[3], frm[4], frm[5]} = mrxc_pkg::MCAST_RST;
		{frm[12], frm[13], frm[14], frm[15], frm[17]} = {16'h8808, op, cls};
	endtask
	task automatic am(input int k, input logic [63:0] w, input logic [4:0] xl);
		repeat (k) @(posedge clk) lwv <= 1;
		@(posedge clk);
		lwv <= 0; amv <= 1; amw <= w;
		@(posedge clk) amv <= 0;
		@(negedge clk);
		chk({hit, hlane}, {1'b1, xl});
		e = serr;
	endtask

	initial begin
		{rd, wr, v, sop, eop, fcs, lf, sb, amv, lwv, prio, ack_go, clr} = '0;
		{addr, wd, dat, lane, amw} = '0;
		pre = mrxc_pkg::PREAMBLE; sfd = mrxc_pkg::SFD;
		bad_count = 0; compares = 0; cyc = 0;
		rst = 1;
		repeat (10) @(posedge clk);
		rst <= 0;
		@(posedge clk) lane <= 5'd6;
		repeat (2) @(negedge clk);
		chk(txm, mrxc_pkg::MARKER_RST[6]);
		chk(hdr, {48'h0180c2000001, 48'h0, 32'h88080001});
		@(posedge clk) prio <= 1;
		repeat (2) @(negedge clk);
		chk(hdr, {48'h0180c2000001, 48'h0, 32'h88080101});
		for (int i = 0; i < 10; i++) begin
			bus(0, ri[i], 32'h0);
			chk(q, rv[i]);
		end
		$display("reset values done");
		bus(1, 44, 32'h12345678);
		repeat (2) @(negedge clk);
		chk(txm, {32'h9a4a2600, 32'h12345678});
		bus(1, mrxc_pkg::R_SPACING, 32'h3);
		am(0, mrxc_pkg::MARKER_RST[19], 5'd19);
		am(4, mrxc_pkg::MARKER_RST[6], 5'd6);
		chk(e, 1'b0);
		am(3, mrxc_pkg::MARKER_RST[0], 5'd0);
		chk(e, 1'b1);
		$display("markers done");
		for (int r = 0; r < 11; r++) begin
			for (int i = 0; i < 128; i++) frm[i] = i[7:0];
			bus(1, 0, {24'h0, rows[r].c});
			bus(1, 1, {17'h0, rows[r].mx});
			bus(1, 2, {24'h0, rows[r].mn});
			fcs <= rows[r].fcs; lf <= rows[r].lf;
			send(rows[r].n, -1, rows[r].pbad ? 56'h55555555555554 : mrxc_pkg::PREAMBLE,
				rows[r].sbad ? 8'hd4 : mrxc_pkg::SFD);
			chk(nbytes, 16'(rows[r].xn));
			chk(lerr, rows[r].xe);
			chk(nbad, {7'h0, rows[r].xb});
			if (rows[r].xg !== 2'h2) chk(ngood, {7'h0, rows[r].xg[0]});
			if (rows[r].xn > 0) chk({fb, lb}, {8'h0, 8'(rows[r].xn - 1)});
			@(posedge clk);
			fcs <= 0;
			lf <= 0;
		end
		$display("frame rows done");
		bus(1, 0, 32'h24);
		pframe(16'h0001, 8'h00);
		send(64, -1, mrxc_pkg::PREAMBLE, mrxc_pkg::SFD);
		chk(nbytes, 16'h0);
		chk(preq, 9'h100);
		repeat (5) @(negedge clk);
		chk(preq, 9'h100);
		@(posedge clk) ack_go <= 1;
		repeat (3) @(negedge clk);
		chk(preq, 9'h000);
		@(posedge clk) ack_go <= 0;
		pframe(16'h0101, 8'h05);
		send(64, -1, mrxc_pkg::PREAMBLE, mrxc_pkg::SFD);
		chk(preq, 9'h005);
		@(posedge clk) ack_go <= 1;
		bus(1, 0, 32'h64);
		ack_go <= 0;
		pframe(16'h0001, 8'h00);
		send(64, -1, mrxc_pkg::PREAMBLE, mrxc_pkg::SFD);
		chk(nbytes, 16'd60);
		@(posedge clk) ack_go <= 1;
		$display("pause done");
		bus(1, 0, 32'h34);
		ack_go <= 0;
		for (int i = 0; i < 128; i++) frm[i] = i[7:0];
		send(64, 20, mrxc_pkg::PREAMBLE, mrxc_pkg::SFD);
		chk({nbytes, lerr}, {16'd20, 1'b1});
		send(64, -1, mrxc_pkg::PREAMBLE, mrxc_pkg::SFD);
		chk(nbytes, 16'h0);
		@(posedge clk) begin lf <= 0; sb <= 1; end
		@(posedge clk) sb <= 0;
		send(64, -1, mrxc_pkg::PREAMBLE, mrxc_pkg::SFD);
		chk({nbytes, lerr}, {16'd60, 1'b0});
		// without acknowledge checking a pause request stands one cycle only
		bus(1, 0, 32'h04);
		pframe(16'h0001, 8'h00);
		send(64, -1, mrxc_pkg::PREAMBLE, mrxc_pkg::SFD);
		chk(preq, 9'h000);
		$display("fault done");
		bus(1, 1, 32'h100);
		@(posedge clk) rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		bus(0, 1, 32'h0);
		chk(q, 32'h2580);
		bus(0, 0, 32'h0);
		chk(q, 32'h24);
		$display("second reset done");
		results();
	end
endmodule // mrxc_top_tb
